// [src/gper_pkg.sv]
package gper_pkg;
    // Register offsets within the power-management I/O space
    localparam logic [7:0]  OFS_EVENT_STATUS = 8'h0C;
    localparam logic [7:0]  OFS_EVENT_ENABLE = 8'h0E;
    // Field positions shared by status and enable, except bit 7 which is in status only
    localparam int          BIT_LID          = 11;
    localparam int          BIT_RING         = 10;
    localparam int          BIT_GPI          = 9;
    localparam int          BIT_USB          = 8;
    localparam int          BIT_THERMAL_ALARM_N_OVR     = 7;
    localparam int          BIT_THERMAL_ALARM_N         = 0;
    // Implemented bits of each register; others read zero
    localparam logic [15:0] STATUS_MASK      = 16'h0F81;
    localparam logic [15:0] ENABLE_MASK      = 16'h0F01;
    // Reset values
    localparam logic [15:0] STATUS_RESET     = 16'h0000;
    localparam logic [15:0] ENABLE_RESET     = 16'h0000;
    // Edges after reset release before pin edge detectors hold real pin values
    localparam logic [1:0]  PRIME_EDGES      = 2'h3;
endpackage : gper_pkg

// [src/gper_sync.sv]
`timescale 1ns/100ps
// Two-flop synchroniser with rising-edge pulse of the synchronised level
module gper_sync (
    input  wire logic clk_in,     // System clock
    input  wire logic rst_n_in,   // Async reset, active low
    input  wire logic level_in,   // Asynchronous level
    output logic      level_out,  // Synchronised level
    output logic      rise_out    // One-cycle pulse on rising edge
);
    logic meta;
    logic prev;

    // First flop feeds only the second flop
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta      <= 1'b0;
            level_out <= 1'b0;
            prev      <= 1'b0;
        end else begin
            meta      <= level_in;
            level_out <= meta;
            prev      <= level_out;
        end
    end

    // Edge taken on the settled level only
    assign rise_out = level_out & ~prev;
endmodule // gper_sync

// [src/gper_regs.sv]
`timescale 1ns/100ps
module gper_regs (
    input  wire logic        CLOCK_IN,                // 20 MHz system clock
    input  wire logic        RESET_N_IN,              // Async reset, active low
    input  wire logic [7:0]  ADDR_IN,                 // I/O offset in PM block
    input  wire logic        WR_IN,                   // Write strobe, one cycle
    input  wire logic        RD_IN,                   // Read strobe, one cycle
    input  wire logic [1:0]  BE_IN,                   // Byte enables
    input  wire logic [15:0] WDATA_IN,                // Write data
    output logic      [15:0] RDATA_OUT,               // Read data, registered
    input  wire logic        LID_IN,                  // Lid pin, async
    input  wire logic        RING_INDICATE_N_IN,      // Ring indicate, active low
    input  wire logic        GP_INPUT_ONE_N_IN,       // GP input 1, active low
    input  wire logic        THERMAL_ALARM_N_IN,      // Thermal alarm, active low when THERMAL_POLARITY_SELECT_IN is 0
    input  wire logic        USB_RESUME_IN,           // USB resume report, same clock
    input  wire logic        THROTTLE_START_IN,       // Override throttle start pulse
    input  wire logic        LID_POLARITY_SELECT_IN,  // 1: lid active high
    input  wire logic        THERMAL_POLARITY_SELECT_IN, // 1: thermal active high
    input  wire logic        SCI_ROUTE_ENABLE_IN,     // Global SCI enable
    output logic             SCI_OUT,                 // SCI request level
    output logic             MGMT_MODE_INTERRUPT_N_OUT, // SMI request, active low
    output logic             RESUME_OUT               // Resume event level
);
    logic [15:0] event_status;
    logic [15:0] event_enable;
    logic        lid_s;
    logic        ring_s;
    logic        gpi_s;
    logic        thermal_alarm_n_s;
    logic        ring_s_d;
    logic        gpi_s_d;
    logic        lid_act;
    logic        thermal_alarm_n_act;
    logic        lid_act_d;
    logic        thermal_alarm_n_act_d;
    logic [1:0]  prime_count;
    logic [1:0]  next_prime_count;
    logic        primed;
    logic        lid_edge;
    logic        ring_edge;
    logic        gpi_edge;
    logic        thermal_alarm_n_edge;

    // Pins pass two flops; ring and GP input inverted to active high first
    // Edge detection is done here, not in the chain, so that it can be masked after reset
    gper_sync u_lid (
        .clk_in    (CLOCK_IN),
        .rst_n_in  (RESET_N_IN),
        .level_in  (LID_IN),
        .level_out (lid_s),
        .rise_out  ()
    );
    gper_sync u_ring (
        .clk_in    (CLOCK_IN),
        .rst_n_in  (RESET_N_IN),
        .level_in  (~RING_INDICATE_N_IN),
        .level_out (ring_s),
        .rise_out  ()
    );
    gper_sync u_gpi (
        .clk_in    (CLOCK_IN),
        .rst_n_in  (RESET_N_IN),
        .level_in  (~GP_INPUT_ONE_N_IN),
        .level_out (gpi_s),
        .rise_out  ()
    );
    gper_sync u_thermal_alarm_n (
        .clk_in    (CLOCK_IN),
        .rst_n_in  (RESET_N_IN),
        .level_in  (THERMAL_ALARM_N_IN),
        .level_out (thermal_alarm_n_s),
        .rise_out  ()
    );

    // Polarity applied after sync so a polarity change cannot glitch a flop chain
    assign lid_act  = ~(lid_s ^ LID_POLARITY_SELECT_IN);
    assign thermal_alarm_n_act = ~(thermal_alarm_n_s ^ THERMAL_POLARITY_SELECT_IN);

    // Previous activity, to set on entry into the active level
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            lid_act_d  <= 1'b1;
            thermal_alarm_n_act_d <= 1'b1;
            ring_s_d   <= 1'b1;
            gpi_s_d    <= 1'b1;
        end else begin
            lid_act_d  <= lid_act;
            thermal_alarm_n_act_d <= thermal_alarm_n_act;
            ring_s_d   <= ring_s;
            gpi_s_d    <= gpi_s;
        end
    end

    // Chains and history flops hold reset values, not pin values, for the first
    // edges after release; pin edges stay masked until they are real.
    // An input active at the first edge counts as active at release; one that goes active later in the window sets its flag.
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            prime_count <= 2'h0;
        end else if (!primed) begin
            prime_count <= next_prime_count;
        end
    end

    // Two-bit count; the cast drops the carry on purpose
    assign next_prime_count = 2'(prime_count + 2'h1);
    assign primed           = (prime_count == gper_pkg::PRIME_EDGES);

    // Set on entry into the active level only, once the detectors are primed
    // A level held across a clear therefore does not set the flag again
    assign lid_edge  = primed & lid_act & ~lid_act_d;
    assign ring_edge = primed & ring_s & ~ring_s_d;
    assign gpi_edge  = primed & gpi_s & ~gpi_s_d;
    assign thermal_alarm_n_edge = primed & thermal_alarm_n_act & ~thermal_alarm_n_act_d;

    // Hardware set sources per bit
    // Same-clock sources need no chain; pins arrive as masked edges
    logic [15:0] hw_set;
    always_comb begin
        hw_set                        = 16'h0000;
        hw_set[gper_pkg::BIT_LID]     = lid_edge;
        hw_set[gper_pkg::BIT_RING]    = ring_edge;
        hw_set[gper_pkg::BIT_GPI]     = gpi_edge;
        hw_set[gper_pkg::BIT_USB]     = USB_RESUME_IN;
        hw_set[gper_pkg::BIT_THERMAL_ALARM_N_OVR] = THROTTLE_START_IN & ~thermal_alarm_n_s;
        hw_set[gper_pkg::BIT_THERMAL_ALARM_N]    = thermal_alarm_n_edge;
    end

    // Address decode and byte-lane write mask
    // A byte write leaves the other lane untouched in both registers
    // Unmapped offsets decode to nothing, so writes there are dropped
    wire         hit_status = (ADDR_IN == gper_pkg::OFS_EVENT_STATUS);
    wire         hit_enable = (ADDR_IN == gper_pkg::OFS_EVENT_ENABLE);
    wire  [15:0] lane_mask  = {{8{BE_IN[1]}}, {8{BE_IN[0]}}};
    wire  [15:0] wr_bits    = WDATA_IN & lane_mask;
    wire  [15:0] sw_clear   = (WR_IN && hit_status) ? wr_bits : 16'h0000;

    // Set wins over a same-cycle write-one clear; zeros leave flags alone
    wire  [15:0] next_event_status = ((event_status & ~sw_clear) | hw_set)
                                     & gper_pkg::STATUS_MASK;
    wire  [15:0] next_event_enable = ((event_enable & ~lane_mask) | wr_bits)
                                     & gper_pkg::ENABLE_MASK;

    // Status flags update every edge: hardware sets, software write-one clears
    // Set wins the race with a clear in the same cycle
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            event_status <= gper_pkg::STATUS_RESET;
        end else begin
            event_status <= next_event_status;
        end
    end

    // Enable register changes only on a write that hits its offset
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            event_enable <= gper_pkg::ENABLE_RESET;
        end else if (WR_IN && hit_enable) begin
            event_enable <= next_event_enable;
        end
    end

    // Enabled flags; override flag has no enable and routes nowhere here
    wire  [15:0] armed = event_status & event_enable;
    // Lid, GP input and thermal share the SCI or SMI choice
    wire         sci_grp = armed[gper_pkg::BIT_LID]
                           | armed[gper_pkg::BIT_GPI]
                           | armed[gper_pkg::BIT_THERMAL_ALARM_N];

    // Ring and USB never go to SMI, so the global enable does not gate them
    wire         wake_sci = armed[gper_pkg::BIT_RING]
                            | armed[gper_pkg::BIT_USB];

    // Group routed to SCI when globally enabled, else to SMI
    wire         next_sci    = (sci_grp & SCI_ROUTE_ENABLE_IN)
                               | wake_sci;
    wire         next_smi    = sci_grp & ~SCI_ROUTE_ENABLE_IN;

    // Resume for all but thermal, which never wakes
    wire         next_resume = armed[gper_pkg::BIT_LID]
                               | armed[gper_pkg::BIT_RING]
                               | armed[gper_pkg::BIT_GPI]
                               | armed[gper_pkg::BIT_USB];

    // Unmapped offsets read zero; reads have no side effects
    wire  [15:0] next_rdata  = hit_status ? event_status :
                               hit_enable ? event_enable : 16'h0000;

    // Event outputs are levels that follow the armed flags one edge later
    // SMI is active low, so reset drives it high
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            SCI_OUT                   <= 1'b0;
            MGMT_MODE_INTERRUPT_N_OUT <= 1'b1;
            RESUME_OUT                <= 1'b0;
        end else begin
            SCI_OUT                   <= next_sci;
            MGMT_MODE_INTERRUPT_N_OUT <= ~next_smi;
            RESUME_OUT                <= next_resume;
        end
    end

    // Read data holds until the next read strobe
    // A read of an unmapped offset still updates, returning zero
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            RDATA_OUT <= 16'h0000;
        end else if (RD_IN) begin
            RDATA_OUT <= next_rdata;
        end
    end
endmodule // gper_regs

// [dv/gper_regs_sva.sv]
`timescale 1ns/100ps
// Port-level checks on the event register bank
module gper_regs_sva (
    input wire logic        CLOCK_IN, RESET_N_IN, WR_IN, RD_IN, USB_RESUME_IN,
    input wire logic        SCI_ROUTE_ENABLE_IN, SCI_OUT, MGMT_MODE_INTERRUPT_N_OUT, RESUME_OUT,
    input wire logic [7:0]  ADDR_IN,
    input wire logic [1:0]  BE_IN,
    input wire logic [15:0] WDATA_IN, RDATA_OUT
);
    logic [15:0] en, en_q;
    logic        route_q;
    wire  [15:0] lanes = {{8{BE_IN[1]}}, {8{BE_IN[0]}}};
    wire         wr_en = WR_IN && (ADDR_IN == gper_pkg::OFS_EVENT_ENABLE);
    wire  [15:0] next_en = wr_en ? ((en & ~lanes) | (WDATA_IN & lanes & gper_pkg::ENABLE_MASK)) : en;
    wire         is_sts = ADDR_IN == gper_pkg::OFS_EVENT_STATUS;
    wire         is_en = ADDR_IN == gper_pkg::OFS_EVENT_ENABLE;
    // Shadow enable; outputs are registered so they follow the copy one edge older
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            en <= 16'h0000; en_q <= 16'h0000; route_q <= 1'h0;
        end else begin
            en <= next_en; en_q <= en; route_q <= SCI_ROUTE_ENABLE_IN;
        end
    end
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (!RESET_N_IN);
    chk_usb_wake_up: assert property (USB_RESUME_IN && en[8] |=> ##1 (SCI_OUT && RESUME_OUT))
        else $error("USB resume gave no SCI and resume");
    chk_quiet_when_off: assert property (en_q == 16'h0000 |-> !SCI_OUT && !RESUME_OUT
        && MGMT_MODE_INTERRUPT_N_OUT) else $error("event output while all enables off");
    chk_smi_source: assert property (!MGMT_MODE_INTERRUPT_N_OUT |-> !route_q
        && (en_q & 16'h0A01) != 16'h0000) else $error("SMI without routed enabled source");
    chk_sci_source: assert property (SCI_OUT |-> (en_q & 16'h0500) != 16'h0000
        || (route_q && (en_q & 16'h0A01) != 16'h0000)) else $error("SCI without enabled source");
    chk_resume_source: assert property (RESUME_OUT |-> (en_q & 16'h0F00) != 16'h0000)
        else $error("resume without enabled wake source");
    chk_read_holds: assert property (!RD_IN |=> $stable(RDATA_OUT))
        else $error("read data changed without a read");
    chk_unmapped_zero: assert property (RD_IN && !is_sts && !is_en |=> RDATA_OUT == 16'h0000)
        else $error("unmapped read not zero");
    chk_status_reserved: assert property (RD_IN && is_sts |=>
        (RDATA_OUT & ~gper_pkg::STATUS_MASK) == 16'h0000) else $error("reserved status bit set");
    chk_enable_readback: assert property (RD_IN && !WR_IN && is_en |=> RDATA_OUT == en_q)
        else $error("enable readback wrong");
endmodule // gper_regs_sva
bind gper_regs gper_regs_sva i_sva (.CLOCK_IN(CLOCK_IN), .RESET_N_IN(RESET_N_IN), .WR_IN(WR_IN),
    .RD_IN(RD_IN), .USB_RESUME_IN(USB_RESUME_IN), .SCI_ROUTE_ENABLE_IN(SCI_ROUTE_ENABLE_IN),
    .SCI_OUT(SCI_OUT), .MGMT_MODE_INTERRUPT_N_OUT(MGMT_MODE_INTERRUPT_N_OUT),
    .RESUME_OUT(RESUME_OUT), .ADDR_IN(ADDR_IN), .BE_IN(BE_IN), .WDATA_IN(WDATA_IN),
    .RDATA_OUT(RDATA_OUT));

// [dv/gper_pins.sv]
`timescale 1ns/100ps
// Board-side pins: each request drives its pin to the active level, else the inactive one
module gper_pins (
    input  wire logic [3:0] req_in,      // Lid, ring, GP input, thermal
    input  wire logic       lid_polarity_select_in,  // Lid active level
    input  wire logic       thermal_polarity_select_in, // Thermal active level
    output logic            lid_out,     // Lid pin
    output logic            ring_n_out,  // Ring indicate, active low
    output logic            gpi_n_out,   // GP input 1, active low
    output logic            thermal_alarm_n_n_out   // Thermal alarm pin
);
    // Pins never float: idle means the inactive level
    assign lid_out = req_in[3] ~^ lid_polarity_select_in;
    assign ring_n_out = ~req_in[2];
    assign gpi_n_out = ~req_in[1];
    assign thermal_alarm_n_n_out = req_in[0] ~^ thermal_polarity_select_in;
endmodule // gper_pins

// [dv/general_purpose_event_regs_tb.sv]
`timescale 1ns/100ps
module general_purpose_event_regs_tb;
    // Event 0 lid, 1 ring, 2 GP input, 3 USB, 4 throttle, 5 thermal; outs are SCI, SMI_N, resume
    typedef struct packed {logic [2:0] evt; logic [15:0] en; logic route; logic [2:0] outs;} gper_row_t;
    localparam gper_row_t ROWS [11] = '{'{3'h0, 16'h0800, 1'h1, 3'h7}, '{3'h0, 16'h0800, 1'h0, 3'h1},
        '{3'h1, 16'h0400, 1'h0, 3'h7}, '{3'h2, 16'h0200, 1'h0, 3'h1}, '{3'h2, 16'h0200, 1'h1, 3'h7},
        '{3'h3, 16'h0100, 1'h0, 3'h7}, '{3'h4, 16'h0F01, 1'h1, 3'h2}, '{3'h5, 16'h0001, 1'h1, 3'h6},
        '{3'h5, 16'h0001, 1'h0, 3'h0}, '{3'h5, 16'h0000, 1'h1, 3'h2}, '{3'h1, 16'h0000, 1'h1, 3'h2}};
    localparam int BITS [6] = '{gper_pkg::BIT_LID, gper_pkg::BIT_RING, gper_pkg::BIT_GPI,
        gper_pkg::BIT_USB, gper_pkg::BIT_THERMAL_ALARM_N_OVR, gper_pkg::BIT_THERMAL_ALARM_N};
    localparam logic [7:0] STS = gper_pkg::OFS_EVENT_STATUS;
    localparam logic [7:0] ENA = gper_pkg::OFS_EVENT_ENABLE;
    logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, usb = 1'h0, thr = 1'h0, route = 1'h0;
    logic lid_polarity_select = 1'h0, thermal_polarity_select = 1'h1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, q, rdata;
    logic [3:0] req = 4'h0;
    logic lid, ring_n, gpi_n, thermal_alarm_n_n, sci, smi_n, res;
    int miscompares = 0, comparisons = 0;
    always #25 clk = ~clk;
    gper_pins i_pins (.req_in(req), .lid_polarity_select_in(lid_polarity_select), .thermal_polarity_select_in(thermal_polarity_select), .lid_out(lid),
        .ring_n_out(ring_n), .gpi_n_out(gpi_n), .thermal_alarm_n_n_out(thermal_alarm_n_n));
    gper_regs i_dut (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WR_IN(wr), .RD_IN(rd),
        .BE_IN(2'h3), .WDATA_IN(wdata), .RDATA_OUT(rdata), .LID_IN(lid), .RING_INDICATE_N_IN(ring_n),
        .GP_INPUT_ONE_N_IN(gpi_n), .THERMAL_ALARM_N_IN(thermal_alarm_n_n), .USB_RESUME_IN(usb),
        .THROTTLE_START_IN(thr), .LID_POLARITY_SELECT_IN(lid_polarity_select),
        .THERMAL_POLARITY_SELECT_IN(thermal_polarity_select),
        .SCI_ROUTE_ENABLE_IN(route), .SCI_OUT(sci), .MGMT_MODE_INTERRUPT_N_OUT(smi_n),
        .RESUME_OUT(res));
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin miscompares++; $display("BAD %s expected %h seen %h", name, exp, seen); end
    endtask
    // Strobes rise and fall on falling edges, so each access spans exactly one rising edge
    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk); addr = a; wdata = d; wr = 1'h1;
        @(negedge clk); wr = 1'h0;
    endtask
    task automatic bus_rd(input logic [7:0] a);
        @(negedge clk); addr = a; rd = 1'h1;
        @(negedge clk); rd = 1'h0; q = rdata;
    endtask
    task automatic results;
        if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'h1;
        foreach (ROWS[i]) begin
            bus_wr(ENA, ROWS[i].en); route = ROWS[i].route;
            @(negedge clk);
            req = (ROWS[i].evt == 3'h5) ? 4'h1 : ((ROWS[i].evt < 3'h3) ? (4'h8 >> ROWS[i].evt) : 4'h0);
            usb = ROWS[i].evt == 3'h3; thr = ROWS[i].evt == 3'h4;
            @(negedge clk); usb = 1'h0; thr = 1'h0;
            repeat (5) @(negedge clk);
            chk("outputs", {13'h0000, sci, smi_n, res}, {13'h0000, ROWS[i].outs});
            bus_rd(STS); chk("status", q, 16'h0001 << BITS[ROWS[i].evt]);
            req = 4'h0;
            bus_wr(STS, 16'h0000); bus_rd(STS); chk("kept", q, 16'h0001 << BITS[ROWS[i].evt]);
            bus_wr(STS, 16'hFFFF); bus_rd(STS); chk("cleared", q, 16'h0000);
            bus_wr(ENA, 16'h0000);
        end
        // Hardware set landing on the same edge as a clear of that flag
        @(negedge clk); addr = STS; wdata = 16'h0100; wr = 1'h1; usb = 1'h1;
        @(negedge clk); wr = 1'h0; usb = 1'h0;
        bus_rd(STS); chk("set_wins", q, 16'h0100);
        bus_wr(ENA, 16'hFFFF); bus_rd(ENA); chk("enable_bits", q, gper_pkg::ENABLE_MASK);
        bus_wr(8'h10, 16'hFFFF); bus_rd(8'h10); chk("unmapped", q, 16'h0000);
        // Opposite pin polarities; the flip itself may set flags, so clear before the event
        lid_polarity_select = 1'h1; thermal_polarity_select = 1'h0; bus_wr(ENA, 16'h0801); route = 1'h1;
        repeat (5) @(negedge clk); bus_wr(STS, 16'hFFFF);
        req = 4'h9; repeat (6) @(negedge clk);
        chk("pol_outs", {13'h0000, sci, smi_n, res}, 16'h0007);
        bus_rd(STS); chk("pol_status", q, 16'h0801);
        req = 4'h0; bus_wr(STS, 16'hFFFF); bus_wr(ENA, 16'h0000);
        // Reset mid-run with ring still held: it must not set again after release
        req = 4'h4; repeat (5) @(negedge clk); rst_n = 1'h0;
        @(negedge clk); chk("reset_outs", {13'h0000, sci, smi_n, res}, 16'h0002);
        rst_n = 1'h1; repeat (5) @(negedge clk);
        bus_rd(STS); chk("status_reset", q, gper_pkg::STATUS_RESET);
        bus_rd(ENA); chk("enable_reset", q, gper_pkg::ENABLE_RESET);
        results;
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk);
        miscompares++;
        results;
    end
endmodule // general_purpose_event_regs_tb
